/* File: logic/uvr_params.svh */
// Offsets, request codes, field positions and reset values for the vendor register bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef UVR_PARAMS_SVH
`define UVR_PARAMS_SVH

// Request type and request codes of the control transfers that are decoded.
`define UVR_RT_VENDOR_OUT   8'h40
`define UVR_RT_VENDOR_IN    8'hc0
`define UVR_RT_CLASS_OUT    8'h21
`define UVR_RQ_REG_WRITE    8'h00
`define UVR_RQ_REG_READ     8'h01
`define UVR_RQ_LINE_CODING  8'h20
`define UVR_RQ_LINE_STATE   8'h22
`define UVR_RQ_SEND_BREAK   8'h23

// Register addresses as carried in the index field.
`define UVR_OFS_DRIVER_SELECT   16'h020d
`define UVR_OFS_SHADOW_FLOW     16'h0216
`define UVR_OFS_SHADOW_FUNC     16'h0217
`define UVR_OFS_SHADOW_DIR      16'h0218
`define UVR_OFS_SHADOW_MASK     16'h0219
`define UVR_OFS_PORT_ENABLE     16'h0c00
`define UVR_OFS_HANDSHAKE       16'h0c06
`define UVR_OFS_RESUME_CHAR     16'h0c07
`define UVR_OFS_PAUSE_CHAR      16'h0c08
`define UVR_OFS_FAULT_FLAGS     16'h0c09
`define UVR_OFS_BREAK_TIME      16'h0c0a
`define UVR_OFS_TURN_DELAY      16'h0c0b
`define UVR_OFS_PIN_FUNCTION    16'h0c0c
`define UVR_OFS_PIN_DIRECTION   16'h0c0d
`define UVR_OFS_PIN_SET         16'h0c0e
`define UVR_OFS_PIN_CLEAR       16'h0c0f
`define UVR_OFS_PIN_LEVEL       16'h0c10
`define UVR_OFS_PIN_IRQ_MASK    16'h0c11

// Field positions and codes.
`define UVR_HALF_DUPLEX_BIT 3
`define UVR_FAULT_LSB       3
`define UVR_LS_DTR_BIT      0
`define UVR_LS_RTS_BIT      1
`define UVR_FLOW_NONE       3'h0
`define UVR_FLOW_HW         3'h1
`define UVR_FLOW_SW         3'h2
`define UVR_FLOW_MDROP_RX   3'h3
`define UVR_FLOW_MDROP_BOTH 3'h4
`define UVR_STOP_ONE        8'h00
`define UVR_STOP_ALT        8'h02
`define UVR_PARITY_MAX      8'h04
`define UVR_BITS_MIN        8'h07
`define UVR_BITS_MAX        8'h09
`define UVR_CODING_LAST     3'h6
`define UVR_RESET_ZERO      1'b0

`endif

/* File: logic/uvr_pkg.sv */
// Types shared by the vendor register bank and its line-coding collector.
// Assumes nothing beyond a SystemVerilog compiler.
package uvr_pkg;

	// Register read answer sequencer.
	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_LOW  = 3'b010,
		RD_HIGH = 3'b100
	} uvr_read_type;

	// Whole state of the register bank.
	typedef struct packed {
		uvr_read_type state;
		logic [11:0]  rd_data;
		logic         drv;
		logic [3:0]   sh_flow;
		logic [3:0]   sh_func;
		logic [5:0]   sh_dir;
		logic [5:0]   sh_mask;
		logic [1:0]   en;
		logic [3:0]   flow;
		logic [7:0]   xon;
		logic [7:0]   xoff;
		logic [4:0]   fault;
		logic [11:0]  brk;
		logic         brk_go;
		logic [3:0]   dly;
		logic [3:0]   func;
		logic [5:0]   dir;
		logic [5:0]   gout;
		logic [5:0]   mask;
		logic         rts;
		logic         dtr;
		logic [31:0]  rate;
		logic         stop_alt;
		logic [2:0]   par;
		logic [3:0]   bits;
		logic         reject;
		logic         in_valid;
		logic [7:0]   in_byte;
		logic         in_last;
		logic         hw;
		logic         sw;
		logic         mrx;
		logic         mtx;
		logic [5:0]   sync1;
		logic [5:0]   sync2;
	} uvr_regs_type;

	// Whole state of the line-coding collector.
	typedef struct packed {
		logic        busy;
		logic [2:0]  cnt;
		logic [55:0] payload;
		logic        done;
		logic        ok;
	} uvr_coding_type;

endpackage

/* File: logic/uvr_lc_if.sv */
// Carrier between the register bank and its line-coding collector.
// Assumes both ends run on the same clock.
interface uvr_lc_if;
	logic        arm;      // Start of a seven byte payload.
	logic        byte_ok;  // Payload byte strobe.
	logic [7:0]  byte_in;  // Payload byte.
	logic        done;     // Payload complete, one cycle.
	logic        fmt_ok;   // Payload holds supported codes.
	logic [55:0] payload;  // Collected payload, byte 0 lowest.

	modport bank (output arm, output byte_ok, output byte_in,
		input done, input fmt_ok, input payload);
	modport coder (input arm, input byte_ok, input byte_in,
		output done, output fmt_ok, output payload);
endinterface

/* File: logic/uvr_line_coding.sv */
// Collector of the seven byte line-coding payload with a format check.
// Assumes payload bytes arrive in order, on the bank's clock, after arm.
`include "uvr_params.svh"

module uvr_line_coding (
	input wire logic clk,      // System clock.
	input wire logic rst,      // Synchronous reset, high.
	uvr_lc_if.coder  lc        // Link to the bank.
);
	uvr_pkg::uvr_coding_type r;
	uvr_pkg::uvr_coding_type next_r;
	logic [7:0] stop_code;
	logic [7:0] par_code;

	assign lc.done    = r.done;
	assign lc.fmt_ok  = r.ok;
	assign lc.payload = r.payload;
	assign stop_code  = r.payload[39:32];
	assign par_code   = r.payload[47:40];

	// Bytes land at their offset; the last byte also decides the format check.
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (lc.arm) begin
			next_r.busy = 1'b1;
			next_r.cnt  = 3'h0;
		end else if (lc.byte_ok && r.busy) begin
			next_r.payload[{r.cnt, 3'b000} +: 8] = lc.byte_in;
			next_r.cnt = r.cnt + 3'h1;
			if (r.cnt == `UVR_CODING_LAST) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				// One and a half stop bits is refused here.
				next_r.ok = (stop_code == `UVR_STOP_ONE || stop_code == `UVR_STOP_ALT)
					&& (par_code <= `UVR_PARITY_MAX)
					&& (lc.byte_in >= `UVR_BITS_MIN) && (lc.byte_in <= `UVR_BITS_MAX);
			end
		end
	end

	// Register the whole collector state.
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

/* File: logic/uvr_top.sv */
// Vendor register bank behind decoded USB control requests of a USB serial bridge.
// Assumes a USB core that presents each setup packet as a one-cycle strobe, streams
// the data stage of a line-coding request as byte strobes, and pulls read answers.
`include "uvr_params.svh"

// Contract
// - Vendor write stores value at indexed register.
// - Vendor read returns register in two bytes.
// - Line coding starts with four-byte bit rate.
// - Stop code 0 one, 2 alternative.
// - Parity codes none, odd, even, mark, space.
// - Data bits accepted are 7, 8, 9.
// - D1 drives RTS, ignored in full duplex.
// - D0 drives DTR.
// - Pin set/clear, break, faults writable while enabled.
// - Enable bit 0 transmitter, bit 1 receiver.
// - Driver select 0 copies shadows on commands.
// - Handshake mode decodes none, hw, sw, multidrop.
module uvr_top (
	input  wire logic        CLK,           // System clock, 50 MHz.
	input  wire logic        SYS_RST,       // Synchronous reset, high.
	input  wire logic        SETUP_VALID,   // Setup packet strobe.
	input  wire logic [7:0]  REQ_TYPE,      // Request type byte.
	input  wire logic [7:0]  REQ_CODE,      // Request byte.
	input  wire logic [15:0] REQ_VALUE,     // Value field.
	input  wire logic [15:0] REQ_INDEX,     // Index field.
	input  wire logic        OUT_VALID,     // Data stage byte strobe.
	input  wire logic [7:0]  OUT_BYTE,      // Data stage byte.
	input  wire logic        IN_READY,      // Core takes the answer byte.
	output logic             IN_VALID,      // Answer byte valid.
	output logic [7:0]       IN_BYTE,       // Answer byte.
	output logic             IN_LAST,       // Answer byte is the last.
	input  wire logic [4:0]  FAULT_EVENT,   // Receiver fault pulses.
	input  wire logic [5:0]  PIN_LEVEL,     // Asynchronous pin levels.
	output logic             TX_ENABLE,     // Transmitter enabled.
	output logic             RX_ENABLE,     // Receiver enabled.
	output logic             RTS,           // Request to send, high active.
	output logic             DTR,           // Terminal ready, high active.
	output logic [31:0]      BIT_RATE,      // Bits per second.
	output logic             STOP_ALT,      // Alternative stop setting.
	output logic [2:0]       PARITY_MODE,   // Parity code.
	output logic [3:0]       DATA_BITS,     // Character width.
	output logic             CODING_REJECT, // Unsupported coding pulse.
	output logic             HALF_DUPLEX,   // Half duplex selected.
	output logic             HW_FLOW,       // Hardware handshake.
	output logic             SW_FLOW,       // Software handshake.
	output logic             MDROP_RX,      // Receive gated by address.
	output logic             MDROP_TX,      // Transmit gated by address.
	output logic [7:0]       RESUME_CHAR,   // Resume character.
	output logic [7:0]       PAUSE_CHAR,    // Pause character.
	output logic [11:0]      BREAK_TIME,    // Break duration.
	output logic             BREAK_START,   // Break request pulse.
	output logic [3:0]       TURN_DELAY,    // Turnaround delay.
	output logic [3:0]       PIN_FUNCTION,  // Pin function select.
	output logic [5:0]       PIN_DIR,       // Pin directions.
	output logic [5:0]       PIN_OUT,       // Pin output levels.
	output logic [5:0]       PIN_IRQ_MASK   // Pin interrupt mask.
);
	uvr_pkg::uvr_regs_type r;
	uvr_pkg::uvr_regs_type next_r;
	uvr_lc_if              lc ();
	logic                  wr_req;
	logic                  rd_req;
	logic                  cdc_cmd;
	logic [11:0]           wr_val;
	logic [11:0]           rd_val;
	logic [4:0]            fault_clr;

	uvr_line_coding u_coding (
		.clk (CLK),
		.rst (SYS_RST),
		.lc  (lc)
	);

	// Request decode; the data stage bytes are forwarded unregistered.
	assign wr_req     = SETUP_VALID && REQ_TYPE == `UVR_RT_VENDOR_OUT
		&& REQ_CODE == `UVR_RQ_REG_WRITE;
	assign rd_req     = SETUP_VALID && REQ_TYPE == `UVR_RT_VENDOR_IN
		&& REQ_CODE == `UVR_RQ_REG_READ && REQ_VALUE == 16'h0000;
	assign cdc_cmd    = SETUP_VALID && REQ_TYPE == `UVR_RT_CLASS_OUT
		&& (REQ_CODE == `UVR_RQ_LINE_CODING || REQ_CODE == `UVR_RQ_LINE_STATE
		|| REQ_CODE == `UVR_RQ_SEND_BREAK);
	assign lc.arm     = cdc_cmd && REQ_CODE == `UVR_RQ_LINE_CODING;
	assign lc.byte_ok = OUT_VALID;
	assign lc.byte_in = OUT_BYTE;
	assign wr_val     = REQ_VALUE[11:0];

	// Read multiplexer; reserved bits and write-only registers answer zero.
	always_comb begin
		rd_val = 12'h000;
		unique case (REQ_INDEX)
			`UVR_OFS_SHADOW_FLOW:   rd_val = {8'h00, r.sh_flow};
			`UVR_OFS_SHADOW_FUNC:   rd_val = {8'h00, r.sh_func};
			`UVR_OFS_SHADOW_DIR:    rd_val = {6'h00, r.sh_dir};
			`UVR_OFS_SHADOW_MASK:   rd_val = {6'h00, r.sh_mask};
			`UVR_OFS_PORT_ENABLE:   rd_val = {10'h000, r.en};
			`UVR_OFS_HANDSHAKE:     rd_val = {8'h00, r.flow};
			`UVR_OFS_RESUME_CHAR:   rd_val = {4'h0, r.xon};
			`UVR_OFS_PAUSE_CHAR:    rd_val = {4'h0, r.xoff};
			`UVR_OFS_FAULT_FLAGS:   rd_val = {4'h0, r.fault, 3'h0};
			`UVR_OFS_BREAK_TIME:    rd_val = r.brk;
			`UVR_OFS_TURN_DELAY:    rd_val = {8'h00, r.dly};
			`UVR_OFS_PIN_FUNCTION:  rd_val = {8'h00, r.func};
			`UVR_OFS_PIN_DIRECTION: rd_val = {6'h00, r.dir};
			`UVR_OFS_PIN_LEVEL:     rd_val = {6'h00, r.sync2};
			`UVR_OFS_PIN_IRQ_MASK:  rd_val = {6'h00, r.mask};
			default:                rd_val = 12'h000;
		endcase
	end

	// Faults are cleared by writing ones; a fault in the same cycle wins.
	assign fault_clr = (wr_req && REQ_INDEX == `UVR_OFS_FAULT_FLAGS)
		? wr_val[`UVR_FAULT_LSB +: 5] : 5'h00;

	// Next state of the whole bank.
	always_comb begin
		next_r = r;
		next_r.brk_go = 1'b0;
		next_r.reject = 1'b0;
		next_r.sync1  = PIN_LEVEL;
		next_r.sync2  = r.sync1;
		next_r.fault  = (r.fault & ~fault_clr) | FAULT_EVENT;
		// Answer bytes go out low first, the upper nibble padded with zero.
		unique case (r.state)
			uvr_pkg::RD_IDLE: begin
			end
			uvr_pkg::RD_LOW: begin
				if (IN_READY) begin
					next_r.in_byte = {4'h0, r.rd_data[11:8]};
					next_r.in_last = 1'b1;
					next_r.state   = uvr_pkg::RD_HIGH;
				end
			end
			uvr_pkg::RD_HIGH: begin
				if (IN_READY) begin
					next_r.in_valid = 1'b0;
					next_r.in_last  = 1'b0;
					next_r.state    = uvr_pkg::RD_IDLE;
				end
			end
			default: begin
				next_r.state = uvr_pkg::RD_IDLE;
			end
		endcase
		// A new read request abandons any answer still in flight.
		if (rd_req) begin
			next_r.rd_data  = rd_val;
			next_r.in_byte  = rd_val[7:0];
			next_r.in_valid = 1'b1;
			next_r.in_last  = 1'b0;
			next_r.state    = uvr_pkg::RD_LOW;
		end
		// Writes are taken whatever the enable state; keeping the port quiet is the host's job.
		if (wr_req) begin
			unique case (REQ_INDEX)
				`UVR_OFS_DRIVER_SELECT: next_r.drv = wr_val[0];
				`UVR_OFS_SHADOW_FLOW:   next_r.sh_flow = wr_val[3:0];
				`UVR_OFS_SHADOW_FUNC:   next_r.sh_func = wr_val[3:0];
				`UVR_OFS_SHADOW_DIR:    next_r.sh_dir = wr_val[5:0];
				`UVR_OFS_SHADOW_MASK:   next_r.sh_mask = wr_val[5:0];
				`UVR_OFS_PORT_ENABLE:   next_r.en = wr_val[1:0];
				`UVR_OFS_HANDSHAKE:     next_r.flow = wr_val[3:0];
				`UVR_OFS_RESUME_CHAR:   next_r.xon = wr_val[7:0];
				`UVR_OFS_PAUSE_CHAR:    next_r.xoff = wr_val[7:0];
				`UVR_OFS_BREAK_TIME: begin
					next_r.brk    = wr_val;
					next_r.brk_go = 1'b1;
				end
				`UVR_OFS_TURN_DELAY:    next_r.dly = wr_val[3:0];
				`UVR_OFS_PIN_FUNCTION:  next_r.func = wr_val[3:0];
				`UVR_OFS_PIN_DIRECTION: next_r.dir = wr_val[5:0];
				`UVR_OFS_PIN_SET:       next_r.gout = r.gout | wr_val[5:0];
				`UVR_OFS_PIN_CLEAR:     next_r.gout = r.gout & ~wr_val[5:0];
				`UVR_OFS_PIN_IRQ_MASK:  next_r.mask = wr_val[5:0];
				default: begin
				end
			endcase
		end
		// Class commands; the reserved upper line-state bits are not looked at.
		if (cdc_cmd && REQ_CODE == `UVR_RQ_LINE_STATE) begin
			next_r.dtr = REQ_VALUE[`UVR_LS_DTR_BIT];
			if (r.flow[`UVR_HALF_DUPLEX_BIT]) begin
				next_r.rts = REQ_VALUE[`UVR_LS_RTS_BIT];
			end
		end
		if (cdc_cmd && REQ_CODE == `UVR_RQ_SEND_BREAK) begin
			next_r.brk    = REQ_VALUE[11:0];
			next_r.brk_go = 1'b1;
		end
		// A standard class driver cannot reach the live registers, so shadows stand in.
		if (cdc_cmd && !r.drv) begin
			next_r.flow = r.sh_flow;
			next_r.func = r.sh_func;
			next_r.dir  = r.sh_dir;
			next_r.mask = r.sh_mask;
		end
		// A refused coding keeps the previous settings in force.
		if (lc.done) begin
			if (lc.fmt_ok) begin
				next_r.rate     = lc.payload[31:0];
				next_r.stop_alt = lc.payload[32 +: 8] == `UVR_STOP_ALT;
				next_r.par      = lc.payload[42:40];
				next_r.bits     = lc.payload[51:48];
			end else begin
				next_r.reject = 1'b1;
			end
		end
		// Handshake decode is registered together with the mode itself.
		next_r.hw  = next_r.flow[2:0] == `UVR_FLOW_HW;
		next_r.sw  = next_r.flow[2:0] == `UVR_FLOW_SW;
		next_r.mrx = next_r.flow[2:0] == `UVR_FLOW_MDROP_RX
			|| next_r.flow[2:0] == `UVR_FLOW_MDROP_BOTH;
		next_r.mtx = next_r.flow[2:0] == `UVR_FLOW_MDROP_BOTH;
	end

	// Register the whole bank; everything clears to zero except the read state, which loads RD_IDLE.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			r       <= '0;
			r.state <= uvr_pkg::RD_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the bank flops.
	assign IN_VALID      = r.in_valid;
	assign IN_BYTE       = r.in_byte;
	assign IN_LAST       = r.in_last;
	assign TX_ENABLE     = r.en[0];
	assign RX_ENABLE     = r.en[1];
	assign RTS           = r.rts;
	assign DTR           = r.dtr;
	assign BIT_RATE      = r.rate;
	assign STOP_ALT      = r.stop_alt;
	assign PARITY_MODE   = r.par;
	assign DATA_BITS     = r.bits;
	assign CODING_REJECT = r.reject;
	assign HALF_DUPLEX   = r.flow[`UVR_HALF_DUPLEX_BIT];
	assign HW_FLOW       = r.hw;
	assign SW_FLOW       = r.sw;
	assign MDROP_RX      = r.mrx;
	assign MDROP_TX      = r.mtx;
	assign RESUME_CHAR   = r.xon;
	assign PAUSE_CHAR    = r.xoff;
	assign BREAK_TIME    = r.brk;
	assign BREAK_START   = r.brk_go;
	assign TURN_DELAY    = r.dly;
	assign PIN_FUNCTION  = r.func;
	assign PIN_DIR       = r.dir;
	assign PIN_OUT       = r.gout;
	assign PIN_IRQ_MASK  = r.mask;

	// Checks on the bank, all in the system clock domain.
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	a_write_enable_reg: assert property (
		wr_req && REQ_INDEX == `UVR_OFS_PORT_ENABLE |=> TX_ENABLE == $past(REQ_VALUE[0])
			&& RX_ENABLE == $past(REQ_VALUE[1]))
		else $error("Port enable did not follow the write.");
	a_read_low_first: assert property (
		rd_req |=> IN_VALID && !IN_LAST && IN_BYTE == $past(rd_val[7:0]))
		else $error("Read answer did not start with the low byte.");
	a_read_high_pad: assert property (
		IN_VALID && !IN_LAST && IN_READY && !SETUP_VALID |=> IN_VALID && IN_LAST
			&& IN_BYTE[7:4] == 4'h0)
		else $error("High answer byte carries upper bits.");
	a_dtr_follows: assert property (
		cdc_cmd && REQ_CODE == `UVR_RQ_LINE_STATE |=> DTR == $past(REQ_VALUE[0]))
		else $error("DTR did not follow the line state.");
	a_rts_full_duplex: assert property (
		cdc_cmd && REQ_CODE == `UVR_RQ_LINE_STATE && !HALF_DUPLEX |=> $stable(RTS))
		else $error("RTS moved in full duplex.");
	a_rate_loaded: assert property (
		lc.done && lc.fmt_ok |=> BIT_RATE == $past(lc.payload[31:0]) && !CODING_REJECT)
		else $error("Bit rate not taken from the payload.");
	a_coding_refused: assert property (
		lc.done && !lc.fmt_ok |=> CODING_REJECT && $stable(STOP_ALT) && $stable(DATA_BITS))
		else $error("Unsupported coding was not refused.");
	a_parity_range: assert property (
		PARITY_MODE <= 3'h4 && (DATA_BITS == 4'h0 || (DATA_BITS >= 4'h7 && DATA_BITS <= 4'h9)))
		else $error("Parity or width outside the accepted codes.");
	a_shadow_copy: assert property (
		cdc_cmd && !r.drv && !wr_req |=> {r.flow, PIN_DIR} == $past({r.sh_flow, r.sh_dir}))
		else $error("Shadows not copied on a class command.");
	a_flow_decode: assert property (
		$onehot0({HW_FLOW, SW_FLOW, MDROP_RX}) && (!MDROP_TX || MDROP_RX))
		else $error("Handshake decode inconsistent.");
	a_fault_sticky: assert property (
		FAULT_EVENT[0] |=> r.fault[0] ##1 (r.fault[0] || $past(fault_clr[0])))
		else $error("Fault event lost against a clear.");
	a_pin_set: assert property (
		wr_req && REQ_INDEX == `UVR_OFS_PIN_SET |=> (PIN_OUT & $past(REQ_VALUE[5:0]))
			== $past(REQ_VALUE[5:0]))
		else $error("Pin set write did not take effect.");

	c_read_done: cover property (rd_req ##1 IN_VALID ##[1:4] !IN_VALID);
	c_coding_ok: cover property (lc.done && lc.fmt_ok);
	c_coding_bad: cover property (lc.done && !lc.fmt_ok);
	c_rts_set: cover property (HALF_DUPLEX && $rose(RTS));
endmodule

/* File: verification/uvr_host_model.sv */
// Host driver model: issues vendor and class control transfers to the register bank.
// Assumes its tasks are entered one nanosecond after a rising edge of CLK.
module uvr_host_model (
	input  wire logic        CLK,         // System clock.
	output logic             SETUP_VALID, // Setup strobe.
	output logic [7:0]       REQ_TYPE,    // Request type.
	output logic [7:0]       REQ_CODE,    // Request.
	output logic [15:0]      REQ_VALUE,   // Value field.
	output logic [15:0]      REQ_INDEX,   // Index field.
	output logic             OUT_VALID,   // Data byte strobe.
	output logic [7:0]       OUT_BYTE,    // Data byte.
	output logic             IN_READY,    // Answer byte taken.
	input  wire logic        IN_VALID,    // Answer byte valid.
	input  wire logic [7:0]  IN_BYTE,     // Answer byte.
	input  wire logic        IN_LAST      // Last answer byte.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] en = 12'h000; // Last enable value, restored after guarded writes.
	// All lines idle at time zero.
	initial begin
		{SETUP_VALID, OUT_VALID, IN_READY} = 3'b000;
		{REQ_TYPE, REQ_CODE, REQ_VALUE, REQ_INDEX, OUT_BYTE} = '0;
	end
	// One setup packet and an idle cycle; released fields show their inverse, so a
	// design that reads them late sees garbage rather than a lucky stale value.
	task automatic setup(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
		input logic [15:0] i);
		{REQ_TYPE, REQ_CODE, REQ_VALUE, REQ_INDEX} = {t, c, v, i};
		SETUP_VALID = 1'b1;
		@(posedge CLK);
		#1;
		SETUP_VALID = 1'b0;
		{REQ_TYPE, REQ_CODE, REQ_VALUE, REQ_INDEX} = ~{t, c, v, i};
		@(posedge CLK);
		#1;
	endtask
	// Register write, wrapped in a port disable unless the register is exempt.
	task automatic reg_write(input logic [15:0] a, input logic [15:0] v);
		logic g;
		g = !(a inside {16'h0c00, 16'h0c09, 16'h0c0a, 16'h0c0e, 16'h0c0f});
		if (g) setup(8'h40, 8'h00, 16'h0000, 16'h0c00);
		setup(8'h40, 8'h00, v, a);
		if (a == 16'h0c00) en = v[11:0];
		if (g) setup(8'h40, 8'h00, {4'h0, en}, 16'h0c00);
	endtask
	// Register read; each answer byte may be held off for a number of cycles.
	task automatic reg_read(input logic [15:0] a, input int stall, output logic [15:0] d,
		output logic [1:0] last);
		setup(8'hc0, 8'h01, 16'h0000, a);
		for (int b = 0; b < 2; b++) begin
			for (int n = 0; n < 20 && IN_VALID !== 1'b1; n++) begin
				@(posedge CLK);
				#1;
			end
			if (stall > 0) begin
				IN_READY = 1'b0;
				repeat (stall) begin
					@(posedge CLK);
					#1;
				end
			end
			d[8*b+:8] = IN_BYTE;
			last[b] = IN_LAST;
			IN_READY = 1'b1;
			@(posedge CLK);
			#1;
		end
		IN_READY = 1'b0;
	endtask
	// Line-coding command and its seven payload bytes, bit rate first.
	task automatic line_coding(input logic [55:0] p);
		setup(8'h21, 8'h20, 16'h0000, 16'h0000);
		for (int b = 0; b < 7; b++) begin
			OUT_BYTE = p[8*b+:8];
			OUT_VALID = 1'b1;
			@(posedge CLK);
			#1;
			OUT_VALID = 1'b0;
			OUT_BYTE = ~p[8*b+:8];
			@(posedge CLK);
			#1;
		end
	endtask
	// Line state carries DTR and RTS only; the reserved bits are sent as zero.
	task automatic line_state(input logic [1:0] v);
		setup(8'h21, 8'h22, {14'h0000, v}, 16'h0000);
	endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the vendor register bank, driven through the host model.
// Assumes the design files under logic/ are compiled first.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed { logic [15:0] a; logic [15:0] v; logic [11:0] r; } uvr_row_type;
	logic        CLK, SYS_RST, SETUP_VALID, OUT_VALID, IN_READY, IN_VALID, IN_LAST;
	logic        TX_ENABLE, RX_ENABLE, RTS, DTR, STOP_ALT, CODING_REJECT, HALF_DUPLEX;
	logic        HW_FLOW, SW_FLOW, MDROP_RX, MDROP_TX, BREAK_START;
	logic [2:0]  PARITY_MODE;
	logic [3:0]  DATA_BITS, TURN_DELAY, PIN_FUNCTION;
	logic [4:0]  FAULT_EVENT;
	logic [5:0]  PIN_LEVEL, PIN_DIR, PIN_OUT, PIN_IRQ_MASK;
	logic [7:0]  REQ_TYPE, REQ_CODE, OUT_BYTE, IN_BYTE, RESUME_CHAR, PAUSE_CHAR;
	logic [11:0] BREAK_TIME;
	logic [15:0] REQ_VALUE, REQ_INDEX, d;
	logic [31:0] BIT_RATE;
	logic [1:0]  l;
	int          mismatches = 0, cmp_count = 0, rej_cnt = 0, brk_cnt = 0, cyc = 0;
	logic [3:0]  modes [5] = '{4'b0000, 4'b1000, 4'b0100, 4'b0010, 4'b0011};
	logic [55:0] bad [3] = '{{8'h07, 8'h00, 8'h01, 32'h0000_2580},
		{8'h08, 8'h05, 8'h00, 32'h0000_2580}, {8'h0a, 8'h00, 8'h00, 32'h0000_2580}};
	// Write value, then expected 12-bit readback; high value bits must be dropped.
	uvr_row_type rows [15] = '{'{16'h0c00, 16'h0003, 12'h003}, '{16'h0c06, 16'hf00b, 12'h00b},
		'{16'h0c07, 16'hf0a5, 12'h0a5}, '{16'h0c08, 16'h1013, 12'h013},
		'{16'h0c0a, 16'hfabc, 12'habc}, '{16'h0c0b, 16'h000f, 12'h00f},
		'{16'h0c0c, 16'h0009, 12'h009}, '{16'h0c0d, 16'h003f, 12'h03f},
		'{16'h0c11, 16'h002a, 12'h02a}, '{16'h0216, 16'h0002, 12'h002},
		'{16'h0217, 16'h0005, 12'h005}, '{16'h0218, 16'h0015, 12'h015},
		'{16'h0219, 16'h0011, 12'h011}, '{16'h020d, 16'h0000, 12'h000},
		'{16'h0123, 16'hffff, 12'h000}};
	uvr_top dut (.CLK, .SYS_RST, .SETUP_VALID, .REQ_TYPE, .REQ_CODE, .REQ_VALUE, .REQ_INDEX,
		.OUT_VALID, .OUT_BYTE, .IN_READY, .IN_VALID, .IN_BYTE, .IN_LAST, .FAULT_EVENT,
		.PIN_LEVEL, .TX_ENABLE, .RX_ENABLE, .RTS, .DTR, .BIT_RATE, .STOP_ALT, .PARITY_MODE,
		.DATA_BITS, .CODING_REJECT, .HALF_DUPLEX, .HW_FLOW, .SW_FLOW, .MDROP_RX, .MDROP_TX,
		.RESUME_CHAR, .PAUSE_CHAR, .BREAK_TIME, .BREAK_START, .TURN_DELAY, .PIN_FUNCTION,
		.PIN_DIR, .PIN_OUT, .PIN_IRQ_MASK);
	uvr_host_model host (.CLK, .SETUP_VALID, .REQ_TYPE, .REQ_CODE, .REQ_VALUE, .REQ_INDEX,
		.OUT_VALID, .OUT_BYTE, .IN_READY, .IN_VALID, .IN_BYTE, .IN_LAST);
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) begin
			@(posedge CLK);
			#1;
		end
	endtask
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// Pulse outputs are counted here, since a one-cycle pulse is easy to miss by polling.
	always @(posedge CLK) begin
		cyc++;
		rej_cnt += (CODING_REJECT === 1'b1);
		brk_cnt += (BREAK_START === 1'b1);
		if (cyc == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	// Main sequence: table first, then the hand-written cases.
	initial begin
		{SYS_RST, FAULT_EVENT, PIN_LEVEL} = {1'b1, 5'h00, 6'h2d};
		repeat (20) @(posedge CLK);
		#1;
		SYS_RST = 1'b0;
		`CHK("reset", '0, {IN_VALID, TX_ENABLE, RX_ENABLE, RTS, DTR, BIT_RATE, PIN_OUT});
		for (int i = 0; i < 15; i++) begin
			host.reg_write(rows[i].a, rows[i].v);
			host.reg_read(rows[i].a, i % 3, d, l);
			`CHK("readback", {4'h0, rows[i].r}, d);
			`CHK("last", 2'b10, l);
		end
		`CHK("half duplex", 1'b1, HALF_DUPLEX);
		`CHK("chars", 24'ha5_13f9, {RESUME_CHAR, PAUSE_CHAR, TURN_DELAY, PIN_FUNCTION});
		for (int k = 1; k < 4; k++) begin
			host.reg_write(16'h0c00, 16'(k));
			`CHK("enable", 2'(k), {RX_ENABLE, TX_ENABLE});
		end
		for (int m = 0; m < 5; m++) begin
			host.reg_write(16'h0c06, 16'(m));
			`CHK("flow", modes[m], {HW_FLOW, SW_FLOW, MDROP_RX, MDROP_TX});
		end
		host.line_state(2'b11);
		`CHK("full duplex lines", 2'b01, {RTS, DTR});
		`CHK("shadow copy", 17'h1_5551, {SW_FLOW, PIN_FUNCTION, PIN_DIR, PIN_IRQ_MASK});
		host.reg_write(16'h020d, 16'h0001);
		host.reg_write(16'h0c06, 16'h0008);
		host.line_state(2'b10);
		`CHK("half duplex lines", 2'b10, {RTS, DTR});
		`CHK("no shadow copy", 2'b10, {HALF_DUPLEX, SW_FLOW});
		host.reg_write(16'h0c0e, 16'h003c);
		`CHK("pin set", 6'h3c, PIN_OUT);
		host.reg_write(16'h0c0f, 16'h000c);
		`CHK("pin clear", 6'h30, PIN_OUT);
		host.reg_write(16'h0c0a, 16'h0123);
		`CHK("break", {12'h123, 32'd2}, {BREAK_TIME, brk_cnt});
		host.setup(8'h21, 8'h23, 16'h0456, 16'h0000);
		`CHK("send break", {12'h456, 32'd3}, {BREAK_TIME, brk_cnt});
		FAULT_EVENT = 5'h05;
		step(1);
		FAULT_EVENT = 5'h00;
		host.reg_read(16'h0c09, 0, d, l);
		`CHK("faults", 16'h0028, d);
		host.reg_write(16'h0c09, 16'h0008);
		host.reg_read(16'h0c09, 0, d, l);
		`CHK("fault clear", 16'h0020, d);
		`CHK("still enabled", 2'b11, {RX_ENABLE, TX_ENABLE});
		for (int p = 0; p < 5; p++) begin
			host.line_coding({8'h07 + 8'(p % 3), 8'(p), p[0] ? 8'h02 : 8'h00, 32'h0000_4b00 + p});
			step(2);
			`CHK("coding", {32'h0000_4b00 + p, p[0], 3'(p), 4'(7 + p % 3)},
				{BIT_RATE, STOP_ALT, PARITY_MODE, DATA_BITS});
		end
		for (int k = 0; k < 3; k++) begin
			host.line_coding(bad[k]);
			step(2);
			`CHK("reject", {k + 1, 32'h0000_4b04, 8'h48},
				{rej_cnt, BIT_RATE, STOP_ALT, PARITY_MODE, DATA_BITS});
		end
		host.setup(8'hc0, 8'h01, 16'h0001, 16'h0c00);
		step(2);
		`CHK("refused read", 1'b0, IN_VALID);
		host.reg_read(16'h0c10, 3, d, l);
		`CHK("pin level", 16'h002d, d);
		SYS_RST = 1'b1;
		step(2);
		SYS_RST = 1'b0;
		`CHK("second reset", '0, {TX_ENABLE, RX_ENABLE, PIN_OUT, BREAK_TIME, HALF_DUPLEX});
		complete_run();
	end
endmodule
